// ---- common/arf_pkg.sv ----
package arf_pkg;
  localparam int ADDR_W = 2;
  localparam logic [1:0] OFF_CTRL0 = 2'h0;
  localparam logic [1:0] OFF_CTRL1 = 2'h1;
  localparam logic [1:0] OFF_RES_HI = 2'h2;
  localparam logic [1:0] OFF_RES_LO = 2'h3;
  localparam int CTRL0_EN_BIT = 0;
  localparam int CTRL0_GO_BIT = 1;
  localparam int CTRL0_CHAN_LSB = 2;
  localparam int CTRL1_PREF_LSB = 0;
  localparam int CTRL1_NREF_BIT = 2;
  localparam int CTRL1_CLK_LSB = 4;
  localparam int CTRL1_FMT_BIT = 7;
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [2:0] CLK_SEL_RST = 3'h0;
  localparam logic [1:0] PREF_RST = 2'h0;
  localparam logic [4:0] CHAN_TEMP = 5'h1D;
  localparam int CLK_MHZ = 200;
  localparam int CONV_TIME_NS = 1100;
  localparam logic [7:0] CONV_CYCLES = 8'((CONV_TIME_NS * CLK_MHZ) / 1000);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] RD_IDLE = 8'h00;

  typedef enum logic [0:0] {
    ARF_IDLE = 1'b0,
    ARF_CONV = 1'b1
  } arf_state_t;

  // Returns {high byte, low byte}; unused bits are forced to zero
  function automatic logic [15:0] arf_format(input logic [9:0] code, input logic right);
    logic [15:0] r;
    r = right ? {6'h00, code} : {code, 6'h00};
    return r;
  endfunction : arf_format
endpackage : arf_pkg

// ---- hdl/arf_result_regs.sv ----
`timescale 1ns/10ps
module arf_result_regs (
  input wire logic clk_sys,
  input wire logic clk_en,
  input wire logic hw_load,
  input wire logic [15:0] hw_data,
  input wire logic sw_wr_hi,
  input wire logic sw_wr_lo,
  input wire logic [7:0] sw_data,
  output logic [7:0] res_hi_q,
  output logic [7:0] res_lo_q
);
  // No reset here: contents survive every reset and power up unknown
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (hw_load) begin
        res_hi_q <= hw_data[15:8];
        res_lo_q <= hw_data[7:0];
      end else begin
        if (sw_wr_hi) begin
          res_hi_q <= sw_data;
        end
        if (sw_wr_lo) begin
          res_lo_q <= sw_data;
        end
      end
    end
  end
endmodule : arf_result_regs

// ---- hdl/arf_top.sv ----
// Operation
// - In left format result bits 1:0 land in bits 7:6 of the low result byte.
// - In right format result bits 9:8 land in bits 1:0 of the high result byte.
// - In right format result bits 7:0 fill the whole low result byte.
// - Both result bytes are software read/write, unknown at power-up and untouched by any reset.
// - The die temperature indicator is routed internally to the converter with no pin.
// - In left format result bits 9:2 land in the high result byte.
// - Loading a result zeroes the six unused bits of the byte that holds only two data bits.
// - The conversion status bit reads one while converting and hardware clears it on completion.
// - Channel code 11101 connects the temperature indicator to the converter input.
`timescale 1ns/10ps
module arf_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic [9:0] ext_code,
  input wire logic [9:0] temp_code,
  output logic [4:0] chan_sel_q,
  output logic conv_en_q,
  output logic conv_busy_q
);
  logic [9:0] ext_s1_q;
  logic [9:0] ext_s2_q;
  logic [9:0] temp_s1_q;
  logic [9:0] temp_s2_q;
  logic go_q;
  logic go_d;
  logic fmt_q;
  logic [2:0] clk_sel_q;
  logic nref_q;
  logic [1:0] pref_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  arf_pkg::arf_state_t state_q;
  arf_pkg::arf_state_t state_d;
  logic [7:0] res_hi_q;
  logic [7:0] res_lo_q;

  // Address decode
  wire sel_c0 = reg_addr == arf_pkg::OFF_CTRL0;
  wire sel_c1 = reg_addr == arf_pkg::OFF_CTRL1;
  wire sel_hi = reg_addr == arf_pkg::OFF_RES_HI;
  wire sel_lo = reg_addr == arf_pkg::OFF_RES_LO;
  wire wr_c0 = reg_wr && sel_c0 && !sys_rst;
  wire wr_c1 = reg_wr && sel_c1 && !sys_rst;
  wire wr_hi = reg_wr && sel_hi && !sys_rst;
  wire wr_lo = reg_wr && sel_lo && !sys_rst;
  wire [7:0] ctrl0_rd = {1'b0, chan_sel_q, go_q, conv_en_q};
  wire [7:0] ctrl1_rd = {fmt_q, clk_sel_q, 1'b0, nref_q, pref_q};
  wire [7:0] rd_mux = sel_c0 ? ctrl0_rd :
                      sel_c1 ? ctrl1_rd :
                      sel_hi ? res_hi_q : res_lo_q;

  // Temperature indicator has its own internal path into the converter
  wire temp_chan = chan_sel_q == arf_pkg::CHAN_TEMP;
  wire [9:0] conv_code = temp_chan ? temp_s2_q : ext_code_pick(ext_s2_q);
  wire cnt_end = cnt_q == arf_pkg::CNT_ZERO;
  wire done = state_q == arf_pkg::ARF_CONV && cnt_end && go_q && conv_en_q;
  wire load = done && clk_en;
  wire [15:0] fmt_word = arf_pkg::arf_format(conv_code, fmt_q);
  wire go_set = wr_c0 && reg_wdata[arf_pkg::CTRL0_GO_BIT];
  wire en_next = wr_c0 ? reg_wdata[arf_pkg::CTRL0_EN_BIT] : conv_en_q;

  function automatic logic [9:0] ext_code_pick(input logic [9:0] v);
    return v;
  endfunction : ext_code_pick

  // A set written in the completion cycle wins over the hardware clear
  always_comb begin
    go_d = go_q;
    if (wr_c0) begin
      go_d = reg_wdata[arf_pkg::CTRL0_GO_BIT] && en_next;
    end
    if (done && !go_set) begin
      go_d = 1'b0;
    end
    if (!en_next) begin
      go_d = 1'b0;
    end
  end

  // Clearing the status bit or the enable aborts a conversion in flight
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      arf_pkg::ARF_IDLE: begin
        if (go_d) begin
          state_d = arf_pkg::ARF_CONV;
          cnt_d = arf_pkg::CONV_CYCLES;
        end
      end
      arf_pkg::ARF_CONV: begin
        if (!go_d && !done) begin
          state_d = arf_pkg::ARF_IDLE;
        end else if (done) begin
          state_d = go_d ? arf_pkg::ARF_CONV : arf_pkg::ARF_IDLE;
          cnt_d = arf_pkg::CONV_CYCLES;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: begin
        state_d = arf_pkg::ARF_IDLE;
      end
    endcase
  end

  // Analog front-end codes come from another domain
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      ext_s1_q <= ext_code;
      ext_s2_q <= ext_s1_q;
      temp_s1_q <= temp_code;
      temp_s2_q <= temp_s1_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      chan_sel_q <= arf_pkg::CHAN_RST;
      conv_en_q <= 1'b0;
      go_q <= 1'b0;
      state_q <= arf_pkg::ARF_IDLE;
      cnt_q <= arf_pkg::CNT_ZERO;
      conv_busy_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_c0) begin
        chan_sel_q <= reg_wdata[arf_pkg::CTRL0_CHAN_LSB +: 5];
      end
      conv_en_q <= en_next;
      go_q <= go_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      conv_busy_q <= go_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fmt_q <= 1'b0;
      clk_sel_q <= arf_pkg::CLK_SEL_RST;
      nref_q <= 1'b0;
      pref_q <= arf_pkg::PREF_RST;
    end else if (clk_en && wr_c1) begin
      fmt_q <= reg_wdata[arf_pkg::CTRL1_FMT_BIT];
      clk_sel_q <= reg_wdata[arf_pkg::CTRL1_CLK_LSB +: 3];
      nref_q <= reg_wdata[arf_pkg::CTRL1_NREF_BIT];
      pref_q <= reg_wdata[arf_pkg::CTRL1_PREF_LSB +: 2];
    end
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata_q <= arf_pkg::RD_IDLE;
    end else if (clk_en) begin
      reg_rdata_q <= reg_rd ? rd_mux : arf_pkg::RD_IDLE;
    end
  end

  // Hardware load beats a same-cycle software write so halves never mix
  arf_result_regs u_res (
    .clk_sys(clk_sys),
    .clk_en(clk_en),
    .hw_load(load),
    .hw_data(fmt_word),
    .sw_wr_hi(wr_hi),
    .sw_wr_lo(wr_lo),
    .sw_data(reg_wdata),
    .res_hi_q(res_hi_q),
    .res_lo_q(res_lo_q)
  );

  left_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    load && !fmt_q |=> res_lo_q[7:6] == $past(conv_code[1:0]))
    else $error("left low byte wrong");
  right_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    load && fmt_q |=> res_hi_q[1:0] == $past(conv_code[9:8]))
    else $error("right high byte wrong");
  right_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    load && fmt_q |=> res_lo_q == $past(conv_code[7:0]))
    else $error("right low byte wrong");
  result_kept_a: assert property (@(posedge clk_sys)
    sys_rst && !load |=> $stable(res_hi_q) && $stable(res_lo_q))
    else $error("result changed under reset");
  temp_path_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    load && temp_chan && !fmt_q |=> res_hi_q == $past(temp_s2_q[9:2]))
    else $error("temperature code not converted");
  left_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    load && !fmt_q |=> res_hi_q == $past(conv_code[9:2]))
    else $error("left high byte wrong");
  zero_fill_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    load |=> ($past(fmt_q) ? res_hi_q[7:2] == 6'h00 : res_lo_q[5:0] == 6'h00))
    else $error("unused bits not zero");
  busy_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_q == arf_pkg::ARF_CONV |-> go_q && conv_busy_q)
    else $error("status low while converting");
  done_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    load && !go_set |=> !go_q && !conv_busy_q)
    else $error("status not cleared at completion");
  temp_select_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    chan_sel_q == 5'h1D |-> conv_code == temp_s2_q)
    else $error("channel 11101 not on temperature");
  pair_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    load |=> {res_hi_q, res_lo_q} == $past(fmt_word))
    else $error("result halves not loaded together");
  idle_status_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_q == arf_pkg::ARF_IDLE |-> !go_q && !conv_busy_q)
    else $error("status high while idle");
  enable_freeze_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clk_en |=> $stable(conv_busy_q) && $stable(cnt_q))
    else $error("conversion moved while frozen");
  result_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && reg_rd && sel_hi |=> reg_rdata_q == $past(res_hi_q))
    else $error("high result byte not readable");
endmodule : arf_top

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  // Settling pause after a channel change; the real figure is software's concern
  localparam int ACQ_CYCLES = 20;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_q;
  logic [9:0] ext_code = 10'h2B5;
  logic [9:0] temp_code = 10'h1CA;
  logic [4:0] chan_sel_q;
  logic conv_en_q;
  logic conv_busy_q;
  logic [7:0] rd_val;
  int fails = 0;
  int checked = 0;

  arf_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .ext_code(ext_code), .temp_code(temp_code), .chan_sel_q(chan_sel_q), .conv_en_q(conv_en_q),
    .conv_busy_q(conv_busy_q));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("Compares %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask : reg_read

  task automatic convert(input logic [4:0] ch, input logic fmt, input logic [9:0] code);
    logic [7:0] exp_hi;
    logic [7:0] exp_lo;
    int i;
    exp_hi = fmt ? {6'h00, code[9:8]} : code[9:2];
    exp_lo = fmt ? code[7:0] : {code[1:0], 6'h00};
    reg_write(arf_pkg::OFF_CTRL1, {fmt, 7'h00});
    reg_write(arf_pkg::OFF_CTRL0, {1'b0, ch, 2'h1});
    repeat (ACQ_CYCLES) @(posedge clk_sys);
    reg_write(arf_pkg::OFF_CTRL0, {1'b0, ch, 2'h3});
    #1;
    chk("busy", {7'h00, conv_busy_q}, 8'h01);
    chk("channel", {3'h0, chan_sel_q}, {3'h0, ch});
    chk("enable", {7'h00, conv_en_q}, 8'h01);
    reg_read(arf_pkg::OFF_CTRL0, rd_val);
    chk("ctrl0 busy", rd_val, {1'b0, ch, 2'h3});
    for (i = 0; i < 400 && conv_busy_q === 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (i == 400) begin
      fails++;
      complete_run();
    end
    reg_read(arf_pkg::OFF_CTRL0, rd_val);
    chk("ctrl0 done", rd_val, {1'b0, ch, 2'h1});
    reg_read(arf_pkg::OFF_RES_HI, rd_val);
    chk("result high", rd_val, exp_hi);
    reg_read(arf_pkg::OFF_RES_LO, rd_val);
    chk("result low", rd_val, exp_lo);
  endtask : convert

  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    reg_read(arf_pkg::OFF_CTRL1, rd_val);
    chk("ctrl1 reset", rd_val, 8'h00);
    reg_read(arf_pkg::OFF_CTRL0, rd_val);
    chk("ctrl0 reset", rd_val, 8'h00);
    convert(5'h01, 1'b0, 10'h2B5);
    convert(5'h1D, 1'b1, 10'h1CA);
    convert(5'h1D, 1'b0, 10'h1CA);
    convert(5'h02, 1'b1, 10'h2B5);
    // A low clock enable must hold a conversion; clearing go then aborts it with no load
    reg_write(arf_pkg::OFF_CTRL0, 8'h0B);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (300) @(posedge clk_sys);
    #1;
    chk("frozen busy", {7'h00, conv_busy_q}, 8'h01);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    reg_write(arf_pkg::OFF_CTRL0, 8'h09);
    #1;
    chk("abort busy", {7'h00, conv_busy_q}, 8'h00);
    reg_read(arf_pkg::OFF_RES_HI, rd_val);
    chk("abort high", rd_val, 8'h02);
    // Software may overwrite both bytes, and no reset may disturb them
    reg_write(arf_pkg::OFF_RES_HI, 8'hA5);
    reg_write(arf_pkg::OFF_RES_LO, 8'h3C);
    reg_read(arf_pkg::OFF_RES_HI, rd_val);
    chk("sw high", rd_val, 8'hA5);
    reg_read(arf_pkg::OFF_RES_LO, rd_val);
    chk("sw low", rd_val, 8'h3C);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    reg_read(arf_pkg::OFF_RES_HI, rd_val);
    chk("kept high", rd_val, 8'hA5);
    reg_read(arf_pkg::OFF_RES_LO, rd_val);
    chk("kept low", rd_val, 8'h3C);
    reg_read(arf_pkg::OFF_CTRL1, rd_val);
    chk("ctrl1 rereset", rd_val, 8'h00);
    complete_run();
  end
endmodule : tb_top
